// file: watchdog_timer_unit.sv
// watchdog timer: control register, unlock sequence and timeout action
//
// Behaviour
// - clearing the enable bit stops every timeout action.
// - an enabled watchdog with prescale 0 to 7 that is not refreshed in time sets the status flag and raises a reset or an interrupt.
// - the watchdog is a 16-bit counter advanced by the 32.768 kHz crystal, not the core clock.
// - a 4-bit prescale field selects the timeout interval.
// - a control write takes effect only right after a single unlock write with bit 0 set, which software repeats for every write.
// - the prescale field sits in bits 7 to 4 of the control register.
// - the timeout is 2^prescale times 512 crystal periods, prescale 0 to 7 being valid.
module watchdog_timer_unit
	import wdt_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// special function register access
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWr,
	input  wire logic [7:0] sfrWdata,
	output logic      [7:0] sfrRdata,
	// one-cycle strobe per crystal period
	input  wire logic       xtalTick,
	// timeout actions
	output logic            wdtResetReq,
	output logic            wdtIrq
);
	import wdt_pkg::*;

	wdt_if link ();

	unlock_e    state_q, state_d;
	logic [3:0] pre_q, pre_d;
	logic       irqSel_q, irqSel_d;
	logic       status_q, status_d;
	logic       enable_q, enable_d;
	logic [7:0] rdata_q, rdata_d;
	logic       resetReq_q, resetReq_d;
	logic       irq_q, irq_d;
	logic       ctrlWr;
	logic       accept;
	logic       fire;
	logic [7:0] ctrlView;

	assign ctrlWr = sfrWr && (sfrAddr == CTRL_ADDR);
	// only the write straight after the arming write is taken
	assign accept = ctrlWr && (state_q == ARMED);
	// a timeout already in flight is dropped once disabled
	assign fire = link.timeout && enable_q;

	// unlock sequencer
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			LOCKED:
				if (ctrlWr && sfrWdata[UNLOCK_BIT])
					state_d = ARMED;
			ARMED:
				// any write, here or elsewhere, ends the window
				if (sfrWr)
					state_d = LOCKED;
		endcase
	end

	// control register
	always_comb
	begin
		pre_d    = pre_q;
		irqSel_d = irqSel_q;
		enable_d = enable_q;
		status_d = status_q;
		if (accept)
		begin
			pre_d    = sfrWdata[PRE_MSB:PRE_LSB];
			irqSel_d = sfrWdata[IRQSEL_BIT];
			enable_d = sfrWdata[ENABLE_BIT];
			status_d = sfrWdata[STATUS_BIT];
		end
		// hardware set wins over a software clear
		if (fire)
			status_d = 1'b1;
	end

	// timeout actions and read-back
	always_comb
	begin
		resetReq_d = fire && !irqSel_q;
		irq_d      = status_q && irqSel_q && enable_q;
		rdata_d    = 8'h00;
		if (sfrAddr == CTRL_ADDR)
			rdata_d = ctrlView;
	end

	assign ctrlView = {pre_q, irqSel_q, status_q, enable_q,
		state_q == ARMED};

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_q    <= LOCKED;
			pre_q      <= CTRL_RESET[PRE_MSB:PRE_LSB];
			irqSel_q   <= CTRL_RESET[IRQSEL_BIT];
			status_q   <= CTRL_RESET[STATUS_BIT];
			enable_q   <= CTRL_RESET[ENABLE_BIT];
			rdata_q    <= 8'h00;
			resetReq_q <= 1'b0;
			irq_q      <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			pre_q      <= pre_d;
			irqSel_q   <= irqSel_d;
			status_q   <= status_d;
			enable_q   <= enable_d;
			rdata_q    <= rdata_d;
			resetReq_q <= resetReq_d;
			irq_q      <= irq_d;
		end
	end

	// counter hookup; refresh only on an accepted write setting enable
	assign link.enable   = enable_q;
	assign link.prescale = pre_q;
	assign link.restart  = accept && sfrWdata[ENABLE_BIT];
	assign link.xtalTick = xtalTick;

	wdt_counter #(
		.WIDTH (CNT_WIDTH)
	) u_counter (
		.mclk (mclk),
		.rst  (rst),
		.link (link.cnt)
	);

	assign sfrRdata    = rdata_q;
	assign wdtResetReq = resetReq_q;
	assign wdtIrq      = irq_q;
endmodule // watchdog_timer_unit

// file: wdt_pkg.sv
// shared constants for the watchdog timer unit
package wdt_pkg;
	// register map
	localparam logic [7:0] CTRL_ADDR  = 8'hC0;
	localparam logic [7:0] CTRL_RESET = 8'h10;
	// control register field positions
	localparam int PRE_MSB    = 7;
	localparam int PRE_LSB    = 4;
	localparam int IRQSEL_BIT = 3;
	localparam int STATUS_BIT = 2;
	localparam int ENABLE_BIT = 1;
	localparam int UNLOCK_BIT = 0;
	// timing, counted in crystal periods
	localparam int CNT_WIDTH  = 16;
	localparam int BASE_SHIFT = 9;
	localparam logic [3:0] PRE_MAX = 4'h7;
	localparam int XTAL_HZ    = 32768;
	// unlock sequencer states
	typedef enum logic [1:0] {
		LOCKED = 2'b01,
		ARMED  = 2'b10
	} unlock_e;
endpackage

// file: wdt_if.sv
// link between the watchdog control logic and its counter
interface wdt_if;
	logic       enable;
	logic [3:0] prescale;
	logic       restart;
	logic       xtalTick;
	logic       timeout;
	modport ctrl (output enable, output prescale, output restart,
		output xtalTick, input timeout);
	modport cnt (input enable, input prescale, input restart,
		input xtalTick, output timeout);
endinterface

// file: wdt_counter.sv
// 16-bit watchdog count advanced once per crystal period
module wdt_counter
	import wdt_pkg::*;
#(
	parameter int WIDTH = CNT_WIDTH
)(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// control side
	wdt_if.cnt        link
);
	logic [WIDTH-1:0] count_q, count_d;
	logic             timeout_q, timeout_d;
	logic [WIDTH-1:0] terminal;
	logic             preValid;
	logic             atEnd;

	// prescale above the documented range never times out
	assign preValid = (link.prescale <= PRE_MAX);
	// terminal count = 2^(pre+9) - 1 crystal periods
	assign terminal = WIDTH'((({(WIDTH+1){1'b0}} | 1)
		<< (link.prescale[2:0] + BASE_SHIFT)) - 1);
	assign atEnd = (count_q == terminal);

	always_comb
	begin
		count_d   = count_q;
		timeout_d = 1'b0;
		if (link.restart || !link.enable)
			count_d = '0;
		else if (link.xtalTick)
		begin
			count_d = atEnd ? '0 : WIDTH'(count_q + 1'b1);
			timeout_d = atEnd && preValid;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			count_q   <= '0;
			timeout_q <= 1'b0;
		end
		else
		begin
			count_q   <= count_d;
			timeout_q <= timeout_d;
		end
	end

	assign link.timeout = timeout_q;
endmodule // wdt_counter

// file: wdt_assertions.sv
// port-level checks on the watchdog timer unit
module wdt_assertions (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic [7:0] sfrAddr,
	input wire logic       sfrWr,
	input wire logic [7:0] sfrRdata,
	input wire logic       xtalTick,
	input wire logic       wdtResetReq,
	input wire logic       wdtIrq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	rst_quiet_a: assert property ($fell(rst) |-> sfrRdata == 8'h00
		&& !wdtResetReq && !wdtIrq) else $error("outputs set after reset");
	pulse_one_a: assert property (wdtResetReq |=> !wdtResetReq)
		else $error("reset request too long");
	act_excl_a: assert property (wdtResetReq |-> !wdtIrq)
		else $error("reset and interrupt together");
	rd_other_a: assert property (sfrAddr != 8'hC0 |=> sfrRdata == 8'h00)
		else $error("read data on other address");
	irq_hold_a: assert property (wdtIrq && !sfrWr && !$past(sfrWr)
		|=> wdtIrq) else $error("interrupt dropped without write");
	status_set_a: assert property (wdtResetReq ##1 sfrAddr == 8'hC0
		|=> sfrRdata[2]) else $error("status not set on timeout");
	irq_cause_a: assert property (wdtIrq && sfrAddr == 8'hC0 &&
		!$past(sfrWr) |=> sfrRdata[3:1] == 3'b111) else $error("bad irq");
	tick_cause_a: assert property (wdtResetReq |-> $past(xtalTick, 2))
		else $error("timeout without crystal tick");
endmodule // wdt_assertions
bind watchdog_timer_unit wdt_assertions chk (.mclk, .rst, .sfrAddr, .sfrWr,
	.sfrRdata, .xtalTick, .wdtResetReq, .wdtIrq);

// file: testbench.sv
// self-checking bench for the watchdog timer unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk = 0, rst = 1, sfrWr = 0, xtalTick = 0;
	logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
	logic       wdtResetReq, wdtIrq;
	int         err_count = 0, n_checks = 0, nRst = 0;
	watchdog_timer_unit DUT (.mclk, .rst, .sfrAddr, .sfrWr, .sfrWdata,
		.sfrRdata, .xtalTick, .wdtResetReq, .wdtIrq);
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) if (wdtResetReq === 1'b1) nRst++;
	task automatic chk(input logic [7:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge mclk);
		{sfrAddr, sfrWr, sfrWdata} = {8'hC0, 1'b1, d};
		@(negedge mclk);
		{sfrAddr, sfrWr} = 9'h000;
	endtask
	// every write needs its own arming write first
	task automatic ww(input logic [7:0] d);
		wr(8'h01);
		wr(d);
		idle(3);
	endtask
	task automatic rd(input logic [7:0] exp);
		@(negedge mclk);
		sfrAddr = 8'hC0;
		@(negedge mclk);
		chk(sfrRdata, exp);
		sfrAddr = 8'h00;
	endtask
	task automatic tk(input int n);
		xtalTick = 1;
		idle(n);
		xtalTick = 0;
		idle(4);
	endtask
	task automatic t_reg;
		rd(8'h10);
		wr(8'h1A);
		rd(8'h10);
		ww(8'h02);
		rd(8'h02);
	endtask
	task automatic t_rst;
		tk(511);
		chk(8'(nRst), 8'h00);
		sfrAddr = 8'hC0;
		tk(1);
		chk(8'(nRst), 8'h01);
		rd(8'h06);
	endtask
	task automatic t_ref;
		ww(8'h12);
		tk(1000);
		ww(8'h12);
		tk(1023);
		chk(8'(nRst), 8'h01);
		tk(1);
		chk(8'(nRst), 8'h02);
	endtask
	task automatic t_irq;
		ww(8'h0A);
		tk(512);
		chk(8'(wdtIrq), 8'h01);
		rd(8'h0E);
		ww(8'h08);
		chk(8'(wdtIrq), 8'h00);
		tk(600);
		chk(8'(nRst), 8'h02);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		idle(20);
		rst = 0;
		t_reg();
		t_rst();
		t_ref();
		t_irq();
		final_report();
	end
	initial
	begin
		#100000;
		err_count++;
		final_report();
	end
endmodule // testbench
